// ### hw/mpsap_pkg.sv
// Purpose: Shared constants for the multiprocessor slave access port.
// Assumes: 22-bit word addresses on the shared bus, 32-bit data.
// Notes:   APB offsets are byte addresses of aligned 32-bit words.
package mpsap_pkg;

    // ----------------------------------------------------------------
    // Shared bus address layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam int DATA_W = 32;
    localparam int REGION_LSB = 19;
    localparam logic [2:0] BCAST_REGION = 3'h7;
    localparam int IO_SEL_BIT = 17;
    localparam int NUM_CHAN = 4;
    localparam int EPB_DEPTH = 6;

    // ----------------------------------------------------------------
    // Read pacing, in cycles from request to answer inclusive
    // ----------------------------------------------------------------
    localparam int MEM_RD_CYCLES = 4;
    localparam int IO_RD_CYCLES = 2;
    localparam logic [1:0] MEM_WAIT_LOAD = 2'(MEM_RD_CYCLES - 3);

    // ----------------------------------------------------------------
    // APB register map
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_SYS_CONFIG = 12'h000;
    localparam logic [11:0] OFF_CHAN_BASE = 12'h010;
    localparam int SC_WS_BIT = 0;
    localparam int SC_BHD_BIT = 1;
    localparam int CC_DEN_BIT = 0;
    localparam int CC_IRQ_DRIVEN_IO_BIT = 1;
    localparam int CC_FLUSH_BIT = 2;
    localparam int CC_RX_NE_BIT = 8;
    localparam int CC_RX_FULL_BIT = 9;
    localparam int CC_TX_EMPTY_BIT = 10;
    localparam int CC_TX_FULL_BIT = 11;
    localparam logic [1:0] SYS_CONFIG_RST = 2'h0;

    // ----------------------------------------------------------------
    // Direct read sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        RD_IDLE = 3'b001,
        RD_WAIT = 3'b010,
        RD_RESP = 3'b100
    } mpsap_rd_state_t;

endpackage : mpsap_pkg

// ### hw/mpsap_top.sv
// Purpose: Slave side of a shared multiprocessor bus: direct reads and
//          writes, broadcast writes, shadow write FIFO, port FIFOs.
// Assumes: Shared bus runs on pclk, so its pins need no synchroniser.
// Notes:   Ack uses output enable; the bench resolves the wired line.
//
// Function
// RQ1: Direct read: ack low, fetch, drive data, ack high
// RQ2: Direct reads served strictly one at a time
// RQ3: Writes per cycle; reads two or four cycles
// RQ4: All accept broadcast writes except own DMA
// RQ5: Broadcast-region read stays local, no bus request
// RQ6: Broadcast odd cycles: unready slave pulls ack low
// RQ7: Master samples ack odd cycles, finishes when high
// RQ8: Even broadcast cycles: slaves release, master precharges
// RQ9: Broadcast one cycle if ready, else three plus
// RQ10: Wait state: slaves drive ack from cycle three
// RQ11: Memory writes pass a two-entry shadow FIFO
// RQ12: Reads of recent two writes come from shadow
// RQ13: Software flushes shadow before mixing word widths
// RQ14: Four channels, six-deep FIFO each direction
// RQ15: Direct accesses bypass port FIFOs
// RQ16: Empty read holds ack; full core write stalls
// RQ17: Full write holds ack; empty core read stalls
// RQ18: Hang disable keeps core from stalling
// RQ19: Flush bit empties FIFO, reads zero
// RQ20: Software avoids enable with flush, clears DMA
// RQ21: Interrupt when read data or write empty
// RQ22: Software masks and clears latched interrupt
// RQ23: Wait-state option adds one cycle to accesses
// RQ24: Port FIFOs keep first-in first-out order
//
// Local design decisions: the register offsets and the APB slave port.
module mpsap_top #(
    parameter logic [2:0] SLAVE_ID = 3'h1,
    parameter int MEM_AW = 10,
    parameter int DEPTH = mpsap_pkg::EPB_DEPTH
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Shared bus, slave view
    input wire logic [21:0] mb_addr,
    input wire logic mb_rd,
    input wire logic mb_wr,
    input wire logic [31:0] mb_wdata,
    input wire logic mb_dma,
    input wire logic is_master,
    output logic mb_ack_o,
    output logic mb_ack_oe,
    output logic [31:0] mb_data_o,
    output logic mb_data_oe,
    // Core port FIFO access
    input wire logic [1:0] core_ch,
    input wire logic core_wr,
    input wire logic [31:0] core_wdata,
    input wire logic core_rd,
    output logic core_stall,
    output logic core_rvalid,
    output logic [31:0] core_rdata,
    // Core memory read
    input wire logic core_mem_rd,
    input wire logic [21:0] core_mem_addr,
    output logic [31:0] core_mem_rdata,
    output logic bus_request_line,
    // Channel interrupts
    output logic [3:0] chan_irq
);
    localparam int NC = mpsap_pkg::NUM_CHAN;
    localparam int NF = 2 * NC;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (SLAVE_ID == 3'h0 || SLAVE_ID == mpsap_pkg::BCAST_REGION)
        begin : g_bad_id
            $error("SLAVE_ID must be 1 to 6");
        end
        if (MEM_AW < 2 || MEM_AW > 16 || DEPTH < 2 || DEPTH > 16)
        begin : g_bad_size
            $error("MEM_AW or DEPTH out of range");
        end
    endgenerate

    // ------------
    // Declarations
    // ------------
    logic ws_q, bhd_q, bc_done_q;
    logic [NC-1:0] den_q, irq_driven_io_q, flush_q;
    logic [31:0] mem [2**MEM_AW];
    logic [MEM_AW-1:0] sh_addr_q [2];
    logic [31:0] sh_data_q [2];
    logic [1:0] sh_vld_q;
    logic [31:0] fmem [NF][DEPTH];
    logic [PW-1:0] wp_q [NF];
    logic [PW-1:0] rp_q [NF];
    logic [CW-1:0] cnt_q [NF];
    logic [NF-1:0] push, pop, full, empty;
    logic [31:0] push_data [NF];
    logic [31:0] head [NF];
    mpsap_pkg::mpsap_rd_state_t rd_state_q;
    logic [1:0] wait_q;
    logic [MEM_AW-1:0] rd_addr_q;
    logic [31:0] rdata_q;
    logic [7:0] acc_q;
    logic [2:0] region;
    logic [1:0] ch;
    logic own, bc, io, epb, ws_ok, slot, wr_hit, wr_ready, wr_commit;
    logic rd_hit, rd_start, mem_wr, apb_wr, apb_setup;

    // ------------
    // Address decode
    // ------------
    assign region = mb_addr[21:mpsap_pkg::REGION_LSB];
    assign own = (region == SLAVE_ID);
    assign bc = (region == mpsap_pkg::BCAST_REGION);
    assign io = mb_addr[mpsap_pkg::IO_SEL_BIT];
    assign epb = io && (mb_addr[16:2] == 15'h0000);
    assign ch = mb_addr[1:0];

    // Extra wait state holds off the first cycle of any access
    assign ws_ok = !ws_q || (acc_q != 8'h00); // RQ23
    // Drive slots are bus cycles 1,3,5 or, with wait state, 3,5,7
    assign slot = !acc_q[0] && (!ws_q || acc_q >= 8'h02); // RQ6 RQ10
    assign wr_hit = mb_wr && (own || (bc && !(is_master && mb_dma))); // RQ4
    assign wr_ready = !(epb && full[ch]);
    assign wr_commit = ce && wr_hit && !bc_done_q && wr_ready
        && (bc ? slot : ws_ok); // RQ3 RQ9
    assign rd_hit = mb_rd && own;
    assign rd_start = ce && rd_hit && (rd_state_q == mpsap_pkg::RD_IDLE)
        && ws_ok && !(epb && empty[NC + ch]); // RQ2 RQ16
    assign mem_wr = wr_commit && !io; // RQ15

    // ------------
    // Acknowledge and data drive
    // ------------
    always_comb
    begin
        mb_ack_oe = 1'b0;
        mb_ack_o = 1'b0;
        if (rd_hit)
        begin
            mb_ack_oe = 1'b1; // RQ1
            mb_ack_o = (rd_state_q == mpsap_pkg::RD_RESP); // RQ1 RQ16
        end
        else if (wr_hit && bc)
        begin
            // Even cycles left to the master's precharge
            mb_ack_oe = slot && !wr_ready && !bc_done_q; // RQ6 RQ8
        end
        else if (wr_hit)
        begin
            mb_ack_oe = 1'b1;
            mb_ack_o = ws_ok && wr_ready; // RQ17
        end
    end

    assign mb_data_o = rdata_q;
    assign mb_data_oe = (rd_state_q == mpsap_pkg::RD_RESP);

    // ------------
    // Access cycle counter
    // ------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q <= 8'h00;
            bc_done_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!(rd_hit || wr_hit) || (wr_commit && !bc)
                || (rd_hit && rd_state_q == mpsap_pkg::RD_RESP))
                acc_q <= 8'h00;
            else
                acc_q <= acc_q + 8'h01;
            // Take a broadcast once even if another slave stretches it
            if (!mb_wr)
                bc_done_q <= 1'b0;
            else if (wr_commit && bc)
                bc_done_q <= 1'b1;
        end
    end

    // ------------
    // Direct read sequencer
    // ------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_state_q <= mpsap_pkg::RD_IDLE;
            wait_q <= 2'h0;
            rd_addr_q <= '0;
            rdata_q <= 32'h0;
        end
        else if (ce)
        begin
            unique case (rd_state_q)
                mpsap_pkg::RD_IDLE:
                begin
                    if (rd_start)
                    begin
                        rd_addr_q <= mb_addr[MEM_AW-1:0];
                        if (io)
                        begin
                            rdata_q <= epb ? head[NC + ch] : 32'h0;
                            rd_state_q <= mpsap_pkg::RD_RESP; // RQ3
                        end
                        else
                        begin
                            wait_q <= mpsap_pkg::MEM_WAIT_LOAD;
                            rd_state_q <= mpsap_pkg::RD_WAIT; // RQ3
                        end
                    end
                end
                mpsap_pkg::RD_WAIT:
                begin
                    if (wait_q == 2'h0)
                    begin
                        if (sh_vld_q[0] && sh_addr_q[0] == rd_addr_q)
                            rdata_q <= sh_data_q[0]; // RQ12
                        else if (sh_vld_q[1] && sh_addr_q[1] == rd_addr_q)
                            rdata_q <= sh_data_q[1]; // RQ12
                        else
                            rdata_q <= mem[rd_addr_q];
                        rd_state_q <= mpsap_pkg::RD_RESP;
                    end
                    else
                        wait_q <= wait_q - 2'h1;
                end
                mpsap_pkg::RD_RESP:
                    rd_state_q <= mpsap_pkg::RD_IDLE; // RQ2
            endcase
        end
    end

    // ------------
    // Shadow write FIFO and memory array
    // ------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_vld_q <= 2'b00;
            sh_addr_q[0] <= '0;
            sh_addr_q[1] <= '0;
            sh_data_q[0] <= 32'h0;
            sh_data_q[1] <= 32'h0;
        end
        else if (ce && mem_wr)
        begin
            sh_addr_q[0] <= mb_addr[MEM_AW-1:0]; // RQ11
            sh_data_q[0] <= mb_wdata;
            sh_addr_q[1] <= sh_addr_q[0];
            sh_data_q[1] <= sh_data_q[0];
            sh_vld_q <= {sh_vld_q[0], 1'b1};
        end
    end

    // Oldest entry retires into the array on each new write once both entries are valid
    always_ff @(posedge pclk)
    begin
        if (ce && mem_wr && sh_vld_q[1])
            mem[sh_addr_q[1]] <= sh_data_q[1]; // RQ11
    end

    // ------------
    // Core memory read: broadcast region stays on chip
    // ------------
    logic mem_local;
    logic [MEM_AW-1:0] cm_addr;
    assign mem_local = core_mem_addr[21:mpsap_pkg::REGION_LSB]
        == mpsap_pkg::BCAST_REGION;
    assign cm_addr = core_mem_addr[MEM_AW-1:0];
    assign bus_request_line = core_mem_rd && !mem_local; // RQ5

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_mem_rdata <= 32'h0;
        else if (ce && core_mem_rd && mem_local)
        begin
            if (sh_vld_q[0] && sh_addr_q[0] == cm_addr)
                core_mem_rdata <= sh_data_q[0]; // RQ5 RQ12
            else if (sh_vld_q[1] && sh_addr_q[1] == cm_addr)
                core_mem_rdata <= sh_data_q[1];
            else
                core_mem_rdata <= mem[cm_addr];
        end
    end

    // ------------
    // Port FIFOs: index c receives from bus, NC+c sends to bus
    // ------------
    genvar k;
    generate
        for (k = 0; k < NF; k++)
        begin : g_fifo
            localparam logic [1:0] KC = 2'(k % NC);
            assign full[k] = (cnt_q[k] == CW'(DEPTH));
            assign empty[k] = (cnt_q[k] == '0);
            assign head[k] = fmem[k][rp_q[k]];
            if (k < NC)
            begin : g_rx
                assign push[k] = wr_commit && epb && ch == KC; // RQ14
                assign push_data[k] = mb_wdata;
                assign pop[k] = ce && core_rd && core_ch == KC && !empty[k];
            end
            else
            begin : g_tx
                assign push[k] = ce && core_wr && core_ch == KC
                    && !full[k]; // RQ14
                assign push_data[k] = core_wdata;
                assign pop[k] = rd_start && epb && ch == KC;
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    wp_q[k] <= '0;
                    rp_q[k] <= '0;
                    cnt_q[k] <= '0;
                end
                else if (ce && flush_q[k % NC])
                begin
                    wp_q[k] <= '0; // RQ19
                    rp_q[k] <= '0;
                    cnt_q[k] <= '0;
                end
                else if (ce)
                begin
                    if (push[k])
                        wp_q[k] <= (wp_q[k] == PW'(DEPTH - 1))
                            ? '0 : wp_q[k] + PW'(1); // RQ24
                    if (pop[k])
                        rp_q[k] <= (rp_q[k] == PW'(DEPTH - 1))
                            ? '0 : rp_q[k] + PW'(1); // RQ24
                    if (push[k] && !pop[k])
                        cnt_q[k] <= cnt_q[k] + CW'(1);
                    else if (pop[k] && !push[k])
                        cnt_q[k] <= cnt_q[k] - CW'(1);
                end
            end
            always_ff @(posedge pclk)
            begin
                if (ce && push[k])
                    fmem[k][wp_q[k]] <= push_data[k];
            end
        end
    endgenerate

    // ------------
    // Core side of port FIFOs
    // ------------
    // Without hang disable the core waits; with it, the access is dropped
    assign core_stall = !bhd_q && ((core_wr && full[NC + core_ch])
        || (core_rd && empty[core_ch])); // RQ16 RQ17 RQ18

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_rvalid <= 1'b0;
            core_rdata <= 32'h0;
        end
        else if (ce)
        begin
            core_rvalid <= pop[core_ch];
            if (pop[core_ch])
                core_rdata <= head[core_ch];
        end
    end

    // Interrupt-driven single-word I/O
    genvar c;
    generate
        for (c = 0; c < NC; c++)
        begin : g_irq
            assign chan_irq[c] = !den_q[c] && irq_driven_io_q[c]
                && (!empty[c] || empty[NC + c]); // RQ21
        end
    endgenerate

    // ------------
    // APB registers
    // ------------
    logic chan_hit;
    logic [1:0] pch;
    logic [31:0] rd_mux;
    assign pch = paddr[3:2];
    assign chan_hit = (paddr[11:4] == mpsap_pkg::OFF_CHAN_BASE[11:4])
        && (paddr[1:0] == 2'h0);
    assign apb_setup = ce && psel && !penable;
    assign apb_wr = ce && psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb
    begin
        rd_mux = 32'h0;
        if (paddr == mpsap_pkg::OFF_SYS_CONFIG)
        begin
            rd_mux[mpsap_pkg::SC_WS_BIT] = ws_q;
            rd_mux[mpsap_pkg::SC_BHD_BIT] = bhd_q;
        end
        else if (chan_hit)
        begin
            rd_mux[mpsap_pkg::CC_DEN_BIT] = den_q[pch];
            rd_mux[mpsap_pkg::CC_IRQ_DRIVEN_IO_BIT] = irq_driven_io_q[pch];
            rd_mux[mpsap_pkg::CC_RX_NE_BIT] = !empty[pch];
            rd_mux[mpsap_pkg::CC_RX_FULL_BIT] = full[pch];
            rd_mux[mpsap_pkg::CC_TX_EMPTY_BIT] = empty[NC + pch];
            rd_mux[mpsap_pkg::CC_TX_FULL_BIT] = full[NC + pch];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (apb_setup)
        begin
            prdata <= rd_mux;
            pslverr <= !(chan_hit || paddr == mpsap_pkg::OFF_SYS_CONFIG);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {bhd_q, ws_q} <= mpsap_pkg::SYS_CONFIG_RST;
            den_q <= '0;
            irq_driven_io_q <= '0;
            flush_q <= '0;
        end
        else if (ce)
        begin
            flush_q <= '0;
            if (apb_wr && paddr == mpsap_pkg::OFF_SYS_CONFIG)
            begin
                ws_q <= pwdata[mpsap_pkg::SC_WS_BIT];
                bhd_q <= pwdata[mpsap_pkg::SC_BHD_BIT];
            end
            if (apb_wr && chan_hit)
            begin
                den_q[pch] <= pwdata[mpsap_pkg::CC_DEN_BIT];
                irq_driven_io_q[pch] <= pwdata[mpsap_pkg::CC_IRQ_DRIVEN_IO_BIT];
                // Flush is a strobe, never stored
                flush_q[pch] <= pwdata[mpsap_pkg::CC_FLUSH_BIT]; // RQ19
            end
        end
    end

endmodule : mpsap_top

// ### tb/mpsap_asserts.sv
// Purpose: Port checks for the slave access port.
// Assumes: ce held high by the bench.
// Notes:   Bound into every instance of the top module.
module mpsap_asserts #(
    parameter logic [2:0] SLAVE_ID = 3'h1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Shared bus
    input wire logic [21:0] mb_addr,
    input wire logic mb_rd,
    input wire logic mb_wr,
    input wire logic mb_dma,
    input wire logic is_master,
    input wire logic mb_ack_o,
    input wire logic mb_ack_oe,
    input wire logic mb_data_oe,
    // Core memory read
    input wire logic core_mem_rd,
    input wire logic [21:0] core_mem_addr,
    input wire logic bus_request_line
);
    logic [3:0] wr_len_q;
    logic own;
    logic bcw;
    assign own = mb_addr[21:19] == SLAVE_ID;
    assign bcw = mb_wr && mb_addr[21:19] == 3'h7;
    // Wraps at 16 on purpose: only the parity is used
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wr_len_q <= 4'h0;
        else
            wr_len_q <= mb_wr ? wr_len_q + 4'h1 : 4'h0;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_req_local;
        bus_request_line == (core_mem_rd && core_mem_addr[21:19] != 3'h7);
    endproperty
    a_req_local: assert property (p_req_local) else $error("bad request");
    property p_ans_ack; mb_data_oe |-> mb_ack_oe && mb_ack_o; endproperty
    a_ans_ack: assert property (p_ans_ack) else $error("answer no ack");
    property p_rd_hold; mb_rd && own && !mb_data_oe |-> mb_ack_oe && !mb_ack_o;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("ack not low");
    property p_rd_mem; $rose(mb_rd) && own && !mb_addr[17]
        |-> !mb_data_oe [*3] ##[1:2] mb_data_oe; endproperty
    a_rd_mem: assert property (p_rd_mem) else $error("mem read pace");
    property p_rd_io; $rose(mb_rd) && own && mb_addr[17] && mb_addr[16:2] != 0
        |-> !mb_data_oe ##[1:2] mb_data_oe; endproperty
    a_rd_io: assert property (p_rd_io) else $error("io read pace");
    property p_one_ans; mb_data_oe |=> !mb_data_oe; endproperty
    a_one_ans: assert property (p_one_ans) else $error("answers overlap");
    property p_bc_even; bcw && wr_len_q[0] |-> !mb_ack_oe; endproperty
    a_bc_even: assert property (p_bc_even) else $error("even drive");
    property p_bc_low; bcw && mb_ack_oe |-> !mb_ack_o; endproperty
    a_bc_low: assert property (p_bc_low) else $error("ack driven high");
    property p_own_dma; bcw && is_master && mb_dma |-> !mb_ack_oe; endproperty
    a_own_dma: assert property (p_own_dma) else $error("own dma taken");
    c_rd_mem: cover property ($rose(mb_rd) && own && !mb_addr[17]);
    c_bc_hold: cover property (bcw && mb_ack_oe);
    c_req: cover property (bus_request_line);
endmodule : mpsap_asserts

bind mpsap_top mpsap_asserts #(.SLAVE_ID(SLAVE_ID)) mpsap_asserts_i (.*);

// ### tb/mpsap_bus_master.sv
// Purpose: Behavioural shared-bus master facing the slave.
// Assumes: Tasks are entered just after a rising edge.
// Notes:   Write data shows the inverted last value when not written.
module mpsap_bus_master (
    // Clock and slave answer
    input wire logic pclk,
    input wire logic ack_o,
    input wire logic ack_oe,
    input wire logic [31:0] rdata,
    // Request
    output logic [21:0] mb_addr,
    output logic mb_rd,
    output logic mb_wr,
    output logic [31:0] mb_wdata
);
    logic ack;
    initial {mb_addr, mb_rd, mb_wr, mb_wdata} = '0;
    // Precharge: high unless someone pulls low
    assign ack = !(ack_oe && !ack_o);
    task automatic xfer(input logic w, input logic [21:0] a,
        input logic [31:0] d, input logic ws,
        output logic [31:0] q, output int n);
        logic bc;
        bc = w && a[21:19] == 3'h7;
        n = 0;
        mb_addr <= a;
        mb_rd <= !w;
        mb_wr <= w;
        mb_wdata <= w ? d : ~mb_wdata;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (!(ack && (!bc || (n[0] && n > (ws ? 2 : 0)))) && n < 500);
        q = rdata;
    endtask : xfer
    task automatic idle();
        mb_rd <= 1'b0;
        mb_wr <= 1'b0;
        mb_wdata <= ~mb_wdata;
        @(posedge pclk);
    endtask : idle
endmodule : mpsap_bus_master

// ### tb/tb.sv
// Purpose: Self-checking bench for the slave access port.
// Assumes: ce tied high; master model resolves the ack line.
// Notes:   Random data and indices from a fixed seed.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] ID = 3'h1;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, e;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, core_wdata = 32'h0, prdata, mb_wdata;
    logic [31:0] mb_data_o, core_rdata, core_mem_rdata, q, d, cq;
    logic mb_rd, mb_wr, mb_ack_o, mb_ack_oe, mb_data_oe, mb_dma = 1'b0;
    logic is_master = 1'b0, core_wr = 1'b0, core_rd = 1'b0, core_stall;
    logic core_mem_rd = 1'b0, core_rvalid, bus_request_line;
    logic [1:0] core_ch = 2'h0;
    logic [21:0] mb_addr, core_mem_addr = 22'h0;
    logic [3:0] chan_irq;
    logic [31:0] mem_m [int];
    logic [31:0] fq [$];
    int wi [$];
    int fails = 0, checks = 0, cyc = 0, n;
    mpsap_top #(.SLAVE_ID(ID)) mpsap_top_i (.*);
    mpsap_bus_master mpsap_bus_master_i (.pclk(pclk), .ack_o(mb_ack_o),
        .ack_oe(mb_ack_oe), .rdata(mb_data_o), .mb_addr(mb_addr),
        .mb_rd(mb_rd), .mb_wr(mb_wr), .mb_wdata(mb_wdata));
    always #10 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic int rd_lat(input logic io, input logic ws);
        return (io ? mpsap_pkg::IO_RD_CYCLES : mpsap_pkg::MEM_RD_CYCLES)
            + int'(ws);
    endfunction : rd_lat
    function automatic logic [21:0] mem_a(input logic [2:0] r, input int i);
        return {r, 9'h0, i[9:0]};
    endfunction : mem_a
    function automatic logic [21:0] io_a(input logic [2:0] r, input int c);
        return {r, 2'b01, 15'h0, c[1:0]};
    endfunction : io_a
    task automatic bus(input logic w, input logic [21:0] a,
        input logic [31:0] v, input logic ws);
        mpsap_bus_master_i.xfer(w, a, v, ws, q, n);
        if (!w || a[21:19] == 3'h7)
            mpsap_bus_master_i.idle();
    endtask : bus
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic core_io(input logic w, input int c, input logic [31:0] v);
        core_ch <= c[1:0];
        core_wdata <= v;
        core_wr <= w;
        core_rd <= !w;
        do
            @(posedge pclk);
        while (core_stall !== 1'b0);
        core_wr <= 1'b0;
        core_rd <= 1'b0;
        @(posedge pclk);
        cq = core_rdata;
    endtask : core_io
    initial
    begin
        void'($urandom(66));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h010, 32'h0);
        chk(q, 32'h400);
        apb(1'b0, 12'h004, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            wi.push_front($urandom % 1024);
            mem_m[wi[0]] = $urandom;
            bus(1'b1, mem_a(ID, wi[0]), mem_m[wi[0]], 1'b0);
            chk(32'(n), 32'h1);
        end
        mpsap_bus_master_i.idle();
        foreach (wi[i])
        begin
            bus(1'b0, mem_a(ID, wi[i]), 32'h0, 1'b0);
            chk(q, mem_m[wi[i]]);
            chk(32'(n), 32'(rd_lat(1'b0, 1'b0)));
        end
        bus(1'b0, io_a(ID, 0) | 22'h4, 32'h0, 1'b0);
        chk(32'(n), 32'(rd_lat(1'b1, 1'b0)));
        d = $urandom;
        bus(1'b1, mem_a(3'h7, 5), d, 1'b0);
        chk(32'(n), 32'h1);
        {is_master, mb_dma} <= 2'h3;
        bus(1'b1, mem_a(3'h7, 5), ~d, 1'b0);
        {is_master, mb_dma} <= 2'h0;
        core_mem_rd <= 1'b1;
        core_mem_addr <= mem_a(3'h7, 5);
        @(posedge pclk);
        chk({31'h0, bus_request_line}, 32'h0);
        core_mem_rd <= 1'b0;
        @(posedge pclk);
        chk(core_mem_rdata, d);
        for (int i = 0; i < 7; i++)
            fq.push_back($urandom);
        for (int i = 0; i < 6; i++)
            bus(1'b1, io_a(ID, 0), fq[i], 1'b0);
        mpsap_bus_master_i.idle();
        apb(1'b0, 12'h010, 32'h0);
        chk(q, 32'h700);
        fork
            bus(1'b1, io_a(3'h7, 0), fq[6], 1'b0);
            begin
                repeat (3) @(posedge pclk);
                core_io(1'b0, 0, 32'h0);
            end
        join
        chk(32'(n >= 3 && n[0]), 32'h1);
        while (fq.size() > 0)
        begin
            if (fq.size() < 7)
                core_io(1'b0, 0, 32'h0);
            chk(cq, fq.pop_front());
        end
        apb(1'b1, 12'h000, 32'h2);
        core_io(1'b0, 0, 32'h0);
        chk({31'h0, core_rvalid}, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        bus(1'b1, io_a(ID, 0), 32'h1, 1'b0);
        mpsap_bus_master_i.idle();
        apb(1'b1, 12'h010, 32'h4);
        apb(1'b0, 12'h010, 32'h0);
        chk(q, 32'h400);
        apb(1'b1, 12'h014, 32'h2);
        chk({28'h0, chan_irq}, 32'h2);
        d = $urandom;
        fork
            bus(1'b0, io_a(ID, 1), 32'h0, 1'b0);
            begin
                repeat (3) @(posedge pclk);
                core_io(1'b1, 1, d);
            end
        join
        chk(q, d);
        chk(32'(n > 3), 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        bus(1'b0, mem_a(ID, wi[0]), 32'h0, 1'b1);
        chk(32'(n), 32'(rd_lat(1'b0, 1'b1)));
        bus(1'b1, mem_a(3'h7, 6), d, 1'b1);
        chk(32'(n), 32'h3);
        stop_test();
    end
endmodule : tb
